//--- shared/susp_pkg.sv
/*
 * constants, types and register map of the usb suspend/resume control block.
 * assumes a 20 mhz clk_sys that keeps running in a low-power domain while
 * the oscillator and pll outputs of this block are switched off.
 */
// What this block does
// [RL1] new function address takes effect from the transaction after address enable is set
// [RL2] suspend only after host leaves bus idle at least 3 ms
// [RL3] suspend sets global suspend flag and interrupts when enabled
// [RL4] firmware stops peripherals, selects power-down, then executes sleep
// [RL5] in power-down during suspend, oscillator and pll are switched off
// [RL6] suspended device restarts on bus activity or external interrupt
// [RL7] external interrupt one during suspend re-enables oscillator, pll and usb logic
// [RL8] remote wakeup drives resume and sets wakeup and resume flags, interrupting
// [RL9] cpu resumes where it slept, then services the pending wakeup interrupt
// [RL10] wake pin wakeup works only while overcurrent register bit 2 is set
// [RL11] low wake pin during suspend starts resume like external interrupt
// [RL12] suspended state flag reads one throughout suspend, hardware-owned
// [RL13] resume active flag set on upstream resume, held until resume finishes
// [RL14] oscillator shuts off only after the cpu sleep is detected
// [RL15] remote wakeup holds the k state 1 to 15 ms, then releases
package susp_pkg;
	localparam logic [7:0] GLOBAL_STATE_OFS = 8'h00;
	localparam logic [7:0] SUSPEND_RESUME_OFS = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
	localparam logic [7:0] OVERCURRENT_DETECT_OFS = 8'h0C;
	localparam logic [7:0] CPU_CONTROL_OFS = 8'h10;
	localparam logic [7:0] FUNCTION_ADDR_OFS = 8'h14;
	localparam int ADDR_EN_POS = 0;
	localparam int RESUME_ACTIVE_POS = 3;
	localparam int SUSPENDED_POS = 4;
	localparam int WAKE_PIN_EN_POS = 2;
	localparam int SLEEP_ENABLE_POS = 0;
	localparam int SLEEP_MODE_POS = 1;
	localparam logic [1:0] SLEEP_MODE_POWER_DOWN = 2'h2;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SUSPEND_IDLE_US = 3000;
	localparam int RESUME_K_US = 10000;
	localparam int IDLE_CYCLES = (SUSPEND_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESUME_K_CYCLES = (RESUME_K_US * 1000) / CLK_PERIOD_NS;
	localparam int TIMER_W = 18;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] PIN_SYNC_RESET = 3'h3;
	typedef struct packed {
		logic firmware_wakeup;
		logic resume;
		logic global_suspend;
	} irq_bits_t;
	typedef struct packed {
		logic ext_int;
		logic wake_pin_n;
		logic bus_idle;
	} pins_t;
	typedef struct packed {
		logic osc;
		logic pll;
		logic usb;
	} power_t;
	typedef enum logic [4:0] {
		ST_ACTIVE = 5'b00001,
		ST_SUSPENDED = 5'b00010,
		ST_POWER_DOWN = 5'b00100,
		ST_RESUME_K = 5'b01000,
		ST_RESUME_HOST = 5'b10000
	} susp_state_t;
endpackage : susp_pkg

//--- design/sync_bits.sv
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes each bit is a slow level; no bit relation is kept across the group.
 */
`timescale 1ns/1ps
module sync_bits #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule : sync_bits

//--- design/cycle_timer.sv
/*
 * down counter: done rises after LOAD edges without restart.
 * assumes restart comes from logic on clk_sys.
 */
`timescale 1ns/1ps
module cycle_timer #(
	parameter int WIDTH = 18,
	parameter int LOAD = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic restart,
	output logic done
);
	localparam logic [WIDTH-1:0] LOAD_V = WIDTH'(LOAD);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	assign cnt_d = restart ? LOAD_V : (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			cnt_q <= LOAD_V;
		else
			cnt_q <= cnt_d;
	end
	assign done = (cnt_q == '0);
endmodule : cycle_timer

//--- design/usb_suspend_resume_control.sv
/*
 * suspend, resume and remote-wakeup control with an ahb-lite register slave.
 * assumes bus_idle, ext_int and wake_pin_n are asynchronous pins, and that
 * txn_start and cpu_sleep are one-cycle pulses from logic on clk_sys.
 */
`timescale 1ns/1ps
module usb_suspend_resume_control #(
	parameter int IDLE_CYC = susp_pkg::IDLE_CYCLES,
	parameter int RESUME_CYC = susp_pkg::RESUME_K_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire susp_pkg::pins_t pins,
	input wire logic txn_start,
	input wire logic cpu_sleep,
	output susp_pkg::power_t power_en,
	output logic resume_k_drive,
	output logic [6:0] function_addr,
	output logic irq
);
	import susp_pkg::*;

	pins_t pins_s;
	susp_state_t st_q;
	susp_state_t st_d;
	irq_bits_t sr_q;
	irq_bits_t sr_d;
	irq_bits_t sr_set;
	irq_bits_t sr_clr;
	irq_bits_t mask_q;
	logic addr_en_q;
	logic wake_pin_en_q;
	logic sleep_enable_q;
	logic [1:0] sleep_mode_q;
	logic [6:0] pending_addr_q;
	logic [6:0] active_addr_q;
	logic resume_active_q;
	logic resume_active_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic wr_pend_q;
	logic [7:0] wr_ofs_q;
	power_t power_q;
	power_t power_d;

	sync_bits #(
		.WIDTH(3),
		.RST_VAL(PIN_SYNC_RESET)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in(pins),
		.sync_out(pins_s)
	);

	// bus slave: zero wait states, always okay
	wire access = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire rd_take = access && !hwrite;
	wire wr_take = access && hwrite;
	wire [7:0] ofs = haddr[7:0];
	wire wr_gs = wr_pend_q && (wr_ofs_q == GLOBAL_STATE_OFS);
	wire wr_mask = wr_pend_q && (wr_ofs_q == IRQ_MASK_OFS);
	wire wr_ovc = wr_pend_q && (wr_ofs_q == OVERCURRENT_DETECT_OFS);
	wire wr_cpu = wr_pend_q && (wr_ofs_q == CPU_CONTROL_OFS);
	wire wr_fa = wr_pend_q && (wr_ofs_q == FUNCTION_ADDR_OFS);
	wire rd_sr = rd_take && (ofs == SUSPEND_RESUME_OFS);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	wire in_suspend = (st_q == ST_SUSPENDED) || (st_q == ST_POWER_DOWN);
	wire [7:0] gs_val = {3'h0, in_suspend, resume_active_q, 2'h0, addr_en_q}; // [RL12]
	wire [7:0] ovc_val = {5'h00, wake_pin_en_q, 2'h0};
	wire [7:0] cpu_val = {5'h00, sleep_mode_q, sleep_enable_q};
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (rd_take)
		begin
			unique case (ofs)
				GLOBAL_STATE_OFS: rdata_d = {24'h000000, gs_val};
				SUSPEND_RESUME_OFS: rdata_d = {29'h0, sr_q};
				IRQ_MASK_OFS: rdata_d = {29'h0, mask_q};
				OVERCURRENT_DETECT_OFS: rdata_d = {24'h000000, ovc_val};
				CPU_CONTROL_OFS: rdata_d = {24'h000000, cpu_val};
				FUNCTION_ADDR_OFS: rdata_d = {25'h0, pending_addr_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdata_d;
			wr_pend_q <= wr_take;
			wr_ofs_q <= ofs;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			addr_en_q <= 1'b0;
			mask_q <= IRQ_RESET;
			wake_pin_en_q <= 1'b0;
			sleep_enable_q <= 1'b0;
			sleep_mode_q <= 2'h0;
			pending_addr_q <= ADDR_RESET;
		end
		else
		begin
			if (wr_gs)
				addr_en_q <= hwdata[ADDR_EN_POS];
			if (wr_mask)
				mask_q <= hwdata[2:0];
			if (wr_ovc)
				wake_pin_en_q <= hwdata[WAKE_PIN_EN_POS];
			if (wr_cpu)
			begin
				sleep_enable_q <= hwdata[SLEEP_ENABLE_POS];
				sleep_mode_q <= hwdata[SLEEP_MODE_POS+1:SLEEP_MODE_POS];
			end
			if (wr_fa)
				pending_addr_q <= hwdata[6:0];
		end
	end

	// address switches only at a transaction boundary, never mid-transaction
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			active_addr_q <= ADDR_RESET;
		else if (addr_en_q && txn_start)
			active_addr_q <= pending_addr_q; // [RL1]
	end
	assign function_addr = active_addr_q;

	// idle and resume timers
	logic idle_done;
	logic k_done;
	cycle_timer #(
		.WIDTH(TIMER_W),
		.LOAD(IDLE_CYC)
	) u_idle_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.restart(!pins_s.bus_idle || (st_q != ST_ACTIVE)),
		.done(idle_done)
	);
	cycle_timer #(
		.WIDTH(TIMER_W),
		.LOAD(RESUME_CYC)
	) u_k_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.restart(st_q != ST_RESUME_K),
		.done(k_done)
	);

	// wake sources; the pin only counts with its enable set
	wire pin_wake = wake_pin_en_q && !pins_s.wake_pin_n; // [RL10] [RL11]
	wire remote_wake = pins_s.ext_int || pin_wake; // [RL7]
	wire host_resume = !pins_s.bus_idle; // [RL6]
	// firmware selects power-down before sleeping; any other sleep keeps clocks
	wire pd_sleep = cpu_sleep && sleep_enable_q && (sleep_mode_q == SLEEP_MODE_POWER_DOWN); // [RL4]

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_ACTIVE:
				if (idle_done && pins_s.bus_idle)
					st_d = ST_SUSPENDED; // [RL2]
			ST_SUSPENDED, ST_POWER_DOWN:
				if (remote_wake)
					st_d = ST_RESUME_K; // [RL7]
				else if (host_resume)
					st_d = ST_RESUME_HOST; // [RL6]
				else if (pd_sleep)
					st_d = ST_POWER_DOWN; // [RL14]
			ST_RESUME_K:
				if (k_done)
					st_d = ST_ACTIVE; // [RL15]
			ST_RESUME_HOST:
				if (pins_s.bus_idle)
					st_d = ST_ACTIVE;
			default:
				st_d = ST_ACTIVE;
		endcase
	end

	wire enter_susp = (st_q == ST_ACTIVE) && (st_d == ST_SUSPENDED);
	wire enter_k = in_suspend && (st_d == ST_RESUME_K);
	wire enter_host = in_suspend && (st_d == ST_RESUME_HOST);
	assign sr_set = '{firmware_wakeup: enter_k, resume: enter_k || enter_host,
		global_suspend: enter_susp}; // [RL3] [RL8]
	assign sr_clr = rd_sr ? 3'h7 : 3'h0;
	// a set in the cycle of the clearing read survives
	assign sr_d = (sr_q & ~sr_clr) | sr_set;
	assign resume_active_d = (enter_k || enter_host) ? 1'b1 : (st_d == ST_ACTIVE) ? 1'b0 :
		resume_active_q; // [RL13]
	assign power_d = '{osc: st_d != ST_POWER_DOWN, pll: st_d != ST_POWER_DOWN,
		usb: st_d != ST_POWER_DOWN}; // [RL5] [RL7]

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_q <= ST_ACTIVE;
			sr_q <= IRQ_RESET;
			resume_active_q <= 1'b0;
			power_q <= 3'h7;
		end
		else
		begin
			st_q <= st_d;
			sr_q <= sr_d;
			resume_active_q <= resume_active_d;
			power_q <= power_d;
		end
	end

	assign power_en = power_q;
	assign resume_k_drive = (st_q == ST_RESUME_K); // [RL8]
	// level stays up until firmware reads the status after waking
	assign irq = |(sr_q & mask_q); // [RL3] [RL9]

	int unsigned k_cnt_q;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			k_cnt_q <= 0;
		else if (!resume_k_drive)
			k_cnt_q <= 0;
		else
			k_cnt_q <= k_cnt_q + 1;
	end

	sequence s_wake_in_pd;
		(st_q == ST_POWER_DOWN) && remote_wake;
	endsequence
	sequence s_k_start;
		$rose(resume_k_drive);
	endsequence

	a_suspend_after_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
		$rose(in_suspend) |-> $past(pins_s.bus_idle) && $past(idle_done))
		else $error("suspend entered without bus idle time");
	a_suspend_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
		$rose(in_suspend) |-> sr_q.global_suspend ##0 (irq == mask_q.global_suspend))
		else $error("suspend flag or interrupt missing");
	a_osc_after_sleep: assert property (@(posedge clk_sys) disable iff (rst) // [RL14]
		$fell(power_en.osc) |-> $past(pd_sleep) && $past(in_suspend))
		else $error("oscillator stopped without cpu power-down sleep");
	a_pd_clocks_off: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
		(st_q == ST_POWER_DOWN) |-> !power_en.osc && !power_en.pll)
		else $error("clocks running in power-down");
	a_wake_restores: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
		s_wake_in_pd |=> power_en.osc && power_en.pll && power_en.usb && resume_k_drive)
		else $error("remote wakeup did not restore clocks");
	a_wake_flags: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
		s_k_start |-> sr_q.firmware_wakeup && sr_q.resume && resume_active_q)
		else $error("wakeup flags not set at resume start");
	a_pin_gated: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
		(in_suspend && !wake_pin_en_q && !pins_s.ext_int && pins_s.bus_idle)
		|=> !resume_k_drive)
		else $error("wake pin acted while disabled");
	a_pin_wakes: assert property (@(posedge clk_sys) disable iff (rst) // [RL11]
		(in_suspend && wake_pin_en_q && !pins_s.wake_pin_n) |=> resume_k_drive)
		else $error("enabled wake pin did not start resume");
	a_host_resume: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
		(in_suspend && host_resume && !remote_wake) |=> resume_active_q && !in_suspend)
		else $error("upstream resume not flagged");
	a_k_length: assert property (@(posedge clk_sys) disable iff (rst) // [RL15]
		$fell(resume_k_drive) |-> ($past(k_cnt_q) + 1 == RESUME_CYC + 1))
		else $error("resume k state length wrong");
	a_addr_switch: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
		(addr_en_q && txn_start) |=> function_addr == $past(pending_addr_q))
		else $error("new address not taken at transaction start");
	a_irq_held: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
		(irq && !rd_sr) |=> irq)
		else $error("interrupt dropped before status read");
endmodule : usb_suspend_resume_control

//--- sim/usb_host_model.sv
/*
 * usb host stand-in: quiet bus reads as idle (j, pulled up), active bus
 * carries traffic with a transaction start every eight cycles.
 * assumes the same clk_sys as the block under test.
 */
`timescale 1ns/1ps
module usb_host_model (
	input wire logic clk_sys,
	input wire logic active,
	output logic bus_idle,
	output logic txn_start
);
	logic [2:0] cnt_q = 3'h0;
	// only the host asks for suspend, by going quiet; activity resumes
	assign bus_idle = !active;
	assign txn_start = active && (cnt_q == 3'h7);
	always_ff @(posedge clk_sys)
	begin
		cnt_q <= cnt_q + 3'h1;
	end
endmodule : usb_host_model

//--- sim/usb_suspend_resume_control_tb.sv
/*
 * self-checking bench: registers, address switch, suspend, sleep gating,
 * remote, host and pin wakeup. assumes short idle and resume counts.
 */
`timescale 1ns/1ps
module usb_suspend_resume_control_tb;
	import susp_pkg::*;
	localparam int IDLE = 20;
	localparam int RES = 16;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic cpu_sleep = 1'b0;
	logic ext_int = 1'b0;
	logic wake_n = 1'b1;
	logic host_on = 1'b1;
	logic [31:0] hrdata;
	logic hreadyout, hresp, bus_idle, txn_start, resume_k_drive, irq;
	logic [6:0] function_addr;
	power_t power_en;
	int error_cnt = 0;
	int checked = 0;
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	usb_host_model u_host (.clk_sys(clk_sys), .active(host_on), .bus_idle(bus_idle),
		.txn_start(txn_start));
	usb_suspend_resume_control #(.IDLE_CYC(IDLE), .RESUME_CYC(RES)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pins({ext_int, wake_n, bus_idle}), .txn_start(txn_start), .cpu_sleep(cpu_sleep),
		.power_en(power_en), .resume_k_drive(resume_k_drive),
		.function_addr(function_addr), .irq(irq));
	task automatic summarize();
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	// holds each phase until hready is seen high; data taken in the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		for (int p = 0; p < 2; p++)
		begin
			for (n = 0; n < 40; n++)
			begin
				@(negedge clk_sys);
				rd = hrdata;
				if (hreadyout === 1'b1)
					break;
			end
			if (n == 40)
			begin
				error_cnt++;
				summarize();
			end
			@(posedge clk_sys);
			if (p == 0)
			begin
				hsel <= 1'b0;
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(nm, exp, x & m);
	endtask : rdc
	task automatic wait_k();
		int n;
		for (n = 0; n < 200; n++)
		begin
			@(negedge clk_sys);
			if (resume_k_drive === 1'b1)
				break;
		end
		if (n == 200)
		begin
			error_cnt++;
			summarize();
		end
	endtask : wait_k
	task automatic go_susp();
		@(posedge clk_sys);
		host_on <= 1'b0;
		cyc(IDLE / 2);
		rdc("early", GLOBAL_STATE_OFS, 32'h1);
		cyc(IDLE);
		rdc("susp", GLOBAL_STATE_OFS, 32'h11);
	endtask : go_susp
	task automatic t_reset();
		chk("power", 32'h7, {29'h0, power_en});
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hready", 32'h1, {31'h0, hreadyout});
		rdc("state", GLOBAL_STATE_OFS, 32'h0);
		rdc("mask", IRQ_MASK_OFS, 32'h0);
		rdc("unmapped", 8'h1C, 32'h0);
	endtask : t_reset
	task automatic t_addr();
		wr(FUNCTION_ADDR_OFS, 32'h2A);
		cyc(10);
		chk("addr_off", 32'h0, {25'h0, function_addr});
		wr(GLOBAL_STATE_OFS, 32'h1);
		cyc(10);
		chk("addr_on", 32'h2A, {25'h0, function_addr});
	endtask : t_addr
	task automatic t_susp();
		wr(IRQ_MASK_OFS, 32'h7);
		go_susp();
		cyc(1);
		chk("irq", 32'h1, {31'h0, irq});
		rdc("status", SUSPEND_RESUME_OFS, 32'h1);
		cyc(1);
		chk("irq_clr", 32'h0, {31'h0, irq});
	endtask : t_susp
	task automatic t_sleep();
		// sleep without power-down mode selected must leave the clocks running
		wr(CPU_CONTROL_OFS, 32'h1);
		@(posedge clk_sys);
		cpu_sleep <= 1'b1;
		@(posedge clk_sys);
		cpu_sleep <= 1'b0;
		cyc(4);
		chk("idle_sleep", 32'h7, {29'h0, power_en});
		wr(CPU_CONTROL_OFS, 32'h5);
		cyc(5);
		chk("awake", 32'h7, {29'h0, power_en});
		@(posedge clk_sys);
		cpu_sleep <= 1'b1;
		@(posedge clk_sys);
		cpu_sleep <= 1'b0;
		cyc(4);
		chk("gated", 32'h0, {29'h0, power_en});
		rdc("still", GLOBAL_STATE_OFS, 32'h11);
	endtask : t_sleep
	task automatic t_remote();
		int n;
		@(posedge clk_sys);
		ext_int <= 1'b1;
		wait_k();
		cyc(2);
		chk("repower", 32'h7, {29'h0, power_en});
		chk("wake_irq", 32'h1, {31'h0, irq});
		for (n = 3; n < 60; n++)
		begin
			@(negedge clk_sys);
			if (resume_k_drive !== 1'b1)
				break;
		end
		chk("k_len", RES + 1, n);
		@(posedge clk_sys);
		ext_int <= 1'b0;
		host_on <= 1'b1;
		rdc("wstat", SUSPEND_RESUME_OFS, 32'h6);
		rdc("active", GLOBAL_STATE_OFS, 32'h1);
	endtask : t_remote
	task automatic t_host();
		go_susp();
		rdc("clr", SUSPEND_RESUME_OFS, 32'h1);
		@(posedge clk_sys);
		host_on <= 1'b1;
		cyc(4);
		chk("no_k", 32'h0, {31'h0, resume_k_drive});
		rdc("hres", GLOBAL_STATE_OFS, 32'h8, 32'h8);
		rdc("hstat", SUSPEND_RESUME_OFS, 32'h2);
		@(posedge clk_sys);
		host_on <= 1'b0;
		cyc(4);
		@(posedge clk_sys);
		host_on <= 1'b1;
		rdc("back", GLOBAL_STATE_OFS, 32'h1);
	endtask : t_host
	task automatic t_pin();
		go_susp();
		rdc("clr2", SUSPEND_RESUME_OFS, 32'h1);
		@(posedge clk_sys);
		wake_n <= 1'b0;
		cyc(10);
		chk("pin_off", 32'h0, {31'h0, resume_k_drive});
		wr(OVERCURRENT_DETECT_OFS, 32'h4);
		wait_k();
		rdc("pstat", SUSPEND_RESUME_OFS, 32'h6);
		@(posedge clk_sys);
		wake_n <= 1'b1;
		cyc(RES + 4);
		@(posedge clk_sys);
		host_on <= 1'b1;
		rdc("pback", GLOBAL_STATE_OFS, 32'h1);
	endtask : t_pin
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(1);
		t_reset();
		t_addr();
		t_susp();
		t_sleep();
		t_remote();
		t_host();
		t_pin();
		summarize();
	end
endmodule : usb_suspend_resume_control_tb
